// ===== dfpc_pkg.sv
// package for the data flash page controller: register addresses, commands, reset values
// assumes an 8-bit special function register bus on a single core clock
package dfpc_pkg;
  localparam logic [7:0] DFPC_ADDR_BYTE_ONE = 8'hBC;
  localparam logic [7:0] DFPC_ADDR_BYTE_TWO = 8'hBD;
  localparam logic [7:0] DFPC_ADDR_BYTE_THREE = 8'hBE;
  localparam logic [7:0] DFPC_ADDR_BYTE_FOUR = 8'hBF;
  localparam logic [7:0] DFPC_ADDR_PAGE_SELECT = 8'hC6;
  localparam logic [7:0] DFPC_ADDR_COMMAND = 8'hB9;
  localparam logic [7:0] DFPC_ADDR_TIMING_LOW = 8'hBA;
  localparam logic [7:0] DFPC_ADDR_TIMING_HIGH = 8'hBB;
  localparam logic [7:0] DFPC_ADDR_TIMING_AUX = 8'hC4;
  localparam logic [7:0] DFPC_CMD_READ = 8'h01;
  localparam logic [7:0] DFPC_CMD_PROGRAM = 8'h02;
  localparam logic [7:0] DFPC_CMD_VERIFY = 8'h04;
  localparam logic [7:0] DFPC_CMD_ERASE = 8'h05;
  localparam logic [7:0] DFPC_CMD_ERASE_ALL = 8'h06;
  localparam logic [7:0] DFPC_ERASED = 8'hFF;
  localparam logic [7:0] DFPC_RST_DATA = 8'h00;
  localparam logic [7:0] DFPC_RST_COMMAND = 8'h00;
  localparam logic [7:0] DFPC_VERIFY_FAIL = 8'h01;
  localparam logic [7:0] DFPC_RST_TIMING_AUX = 8'hC9;
  // 100 us at 11.0592 MHz is 1105.92, so 1106 ticks of the master clock
  localparam logic [15:0] DFPC_RST_TIMING_WORD = 16'h0452;
  localparam int DFPC_PAGES = 160;
  localparam logic [7:0] DFPC_LAST_PAGE = 8'h9F;
  localparam int DFPC_PAGE_BYTES = 4;
  // operation lengths in multiples of the 100 us timing unit
  localparam int DFPC_ERASE_TIME_MS = 20;
  localparam int DFPC_PROGRAM_TIME_US = 250;
  localparam int DFPC_UNIT_US = 100;
  localparam int DFPC_ERASE_UNITS = DFPC_ERASE_TIME_MS * 1000 / DFPC_UNIT_US;
  localparam int DFPC_PROGRAM_UNITS = (DFPC_PROGRAM_TIME_US + DFPC_UNIT_US - 1) / DFPC_UNIT_US;
  localparam int DFPC_CORE_CLK_MHZ = 125;
  typedef enum logic [2:0] {DFPC_IDLE, DFPC_READ, DFPC_PROGRAM, DFPC_VERIFY,
    DFPC_ERASE, DFPC_ERASE_ALL} dfpc_state_e;
endpackage

// ===== dfpc_timer.sv
// unit timer: counts timing-word ticks into 100 us units, then units into a whole operation
// assumes start is a one-cycle pulse from the sequencer on the same clock
`timescale 1ns/1ps
module dfpc_timer #(
  parameter int UNIT_WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [15:0] timing_word,
  input wire logic [UNIT_WIDTH-1:0] units,
  output logic done
);
  import dfpc_pkg::*;
  logic [15:0] tick_count;
  logic [UNIT_WIDTH-1:0] unit_count;
  logic running;
  wire tick_end = (tick_count + 16'h0001 >= timing_word);
  wire unit_end = (unit_count + {{(UNIT_WIDTH-1){1'b0}}, 1'b1} >= units);

  initial begin
    if (UNIT_WIDTH < 8) $error("unit width too small for the erase duration");
  end

  // the word is read live so software may retune it, but not mid-operation safely
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_count <= 16'h0000;
      unit_count <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        tick_count <= 16'h0000;
        unit_count <= '0;
        running <= 1'b1;
      end else if (running) begin
        if (tick_end) begin
          tick_count <= 16'h0000;
          if (unit_end) begin
            running <= 1'b0;
            done <= 1'b1;
          end else begin
            unit_count <= unit_count + {{(UNIT_WIDTH-1){1'b0}}, 1'b1};
          end
        end else begin
          tick_count <= tick_count + 16'h0001;
        end
      end
    end
  end
endmodule

// ===== dfpc_core.sv
// data flash page controller: register file, command sequencer and the data array model
// assumes an 8-bit register bus with one-cycle write and read strobes on core_clk
`timescale 1ns/1ps
// Overview of operation
// - array is 640 bytes as 160 pages of four bytes, pages 00H to 9FH
// - an 8-bit page select register chooses the page for every command except 06H
// - four page data registers hold the page bytes in order
// - command 01H copies the addressed page into the data registers
// - command 02H writes the data registers into the addressed page
// - command 04H compares; command register then reads zero on match, nonzero otherwise
// - command 05H erases only the selected page
// - command 06H erases all 160 pages
// - erases last about 20 ms, page program three 100 us units, about 300 us
// - page read finishes within one instruction cycle
// - a 16-bit timing word of two byte registers paces program and erase
// - timing word resets to suit an 11.0592 MHz master clock
// - writing a command starts the operation at once
// - the core is stalled from the command write until the operation ends
// - interrupts are held off during the stall while timers run on
// - erased bytes read FFH; programming only succeeds on bytes holding FFH
module dfpc_core #(
  parameter int PAGES = 160
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic core_stall,
  output logic irq_hold
);
  import dfpc_pkg::*;

  initial begin
    if (PAGES != DFPC_PAGES) $error("array must hold exactly 160 pages");
  end

  logic [7:0] page_data_bytes [DFPC_PAGE_BYTES];
  logic [7:0] page_select;
  logic [7:0] command_and_result;
  logic [7:0] erase_timing_low;
  logic [7:0] erase_timing_high;
  logic [7:0] timing_aux;
  logic [7:0] flash_array [PAGES][DFPC_PAGE_BYTES];
  dfpc_state_e state;
  logic timer_start;
  logic [7:0] timer_units;
  logic timer_done;

  wire busy = (state != DFPC_IDLE);
  wire cmd_write = reg_write && (reg_addr == DFPC_ADDR_COMMAND) && !busy;
  wire page_ok = (page_select <= DFPC_LAST_PAGE);
  wire [7:0] page_idx = page_ok ? page_select : 8'h00;
  wire [15:0] timing_word = {erase_timing_high, erase_timing_low};
  wire sel_byte_one = (reg_addr == DFPC_ADDR_BYTE_ONE);
  wire sel_byte_two = (reg_addr == DFPC_ADDR_BYTE_TWO);
  wire sel_byte_three = (reg_addr == DFPC_ADDR_BYTE_THREE);
  wire sel_byte_four = (reg_addr == DFPC_ADDR_BYTE_FOUR);
  wire sel_page = (reg_addr == DFPC_ADDR_PAGE_SELECT);
  wire sel_cmd = (reg_addr == DFPC_ADDR_COMMAND);
  wire sel_tlow = (reg_addr == DFPC_ADDR_TIMING_LOW);
  wire sel_thigh = (reg_addr == DFPC_ADDR_TIMING_HIGH);
  wire sel_taux = (reg_addr == DFPC_ADDR_TIMING_AUX);
  wire [3:0] sel_bytes = {sel_byte_four, sel_byte_three, sel_byte_two, sel_byte_one};
  wire verify_match = (flash_array[page_idx][0] == page_data_bytes[0]) &&
    (flash_array[page_idx][1] == page_data_bytes[1]) &&
    (flash_array[page_idx][2] == page_data_bytes[2]) &&
    (flash_array[page_idx][3] == page_data_bytes[3]);
  wire [7:0] next_rdata = sel_byte_one ? page_data_bytes[0] :
    sel_byte_two ? page_data_bytes[1] :
    sel_byte_three ? page_data_bytes[2] :
    sel_byte_four ? page_data_bytes[3] :
    sel_page ? page_select :
    sel_cmd ? command_and_result :
    sel_tlow ? erase_timing_low :
    sel_thigh ? erase_timing_high :
    sel_taux ? timing_aux : 8'h00;
  // program and erase need the timer; read and verify finish in one cycle
  wire is_timed = (reg_wdata == DFPC_CMD_PROGRAM) || (reg_wdata == DFPC_CMD_ERASE) ||
    (reg_wdata == DFPC_CMD_ERASE_ALL);
  wire [7:0] next_units = (reg_wdata == DFPC_CMD_PROGRAM) ? 8'(DFPC_PROGRAM_UNITS) :
    8'(DFPC_ERASE_UNITS);
  // erase-all ignores the page select, so a stale out-of-range page must not end its stall
  wire run_stall = busy && !(state == DFPC_READ || state == DFPC_VERIFY) && !timer_done &&
    (page_ok || state == DFPC_ERASE_ALL);
  wire cmd_acts = (reg_wdata >= DFPC_CMD_READ) && (reg_wdata <= DFPC_CMD_ERASE_ALL) &&
    (reg_wdata != 8'h03);

  dfpc_timer #(
    .UNIT_WIDTH(8)
  ) u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .start(timer_start),
    .timing_word(timing_word),
    .units(timer_units),
    .done(timer_done)
  );

  // register writes; the data bytes are locked while an operation runs
  genvar gi;
  generate
    for (gi = 0; gi < DFPC_PAGE_BYTES; gi++) begin : g_data
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          page_data_bytes[gi] <= DFPC_RST_DATA;
        end else if (state == DFPC_READ && page_ok) begin
          page_data_bytes[gi] <= flash_array[page_idx][gi];
        end else if (reg_write && sel_bytes[gi] && !busy) begin
          page_data_bytes[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      page_select <= DFPC_RST_DATA;
      erase_timing_low <= DFPC_RST_TIMING_WORD[7:0];
      erase_timing_high <= DFPC_RST_TIMING_WORD[15:8];
      timing_aux <= DFPC_RST_TIMING_AUX;
    end else if (reg_write && !busy) begin
      if (sel_page) begin
        page_select <= reg_wdata;
      end
      if (sel_tlow) begin
        erase_timing_low <= reg_wdata;
      end
      if (sel_thigh) begin
        erase_timing_high <= reg_wdata;
      end
      // stored but unused; its only legal value is the reset one
      if (sel_taux) begin
        timing_aux <= reg_wdata;
      end
    end
  end

  // sequencer: the command starts in the cycle after its write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= DFPC_IDLE;
      command_and_result <= DFPC_RST_COMMAND;
      timer_start <= 1'b0;
      timer_units <= 8'h00;
    end else begin
      timer_start <= 1'b0;
      unique case (state)
        DFPC_IDLE: begin
          if (cmd_write) begin
            command_and_result <= reg_wdata;
            timer_units <= next_units;
            timer_start <= is_timed && (page_ok || reg_wdata == DFPC_CMD_ERASE_ALL);
            // reserved codes stay in idle and start nothing; only the command register stores them
            if (reg_wdata == DFPC_CMD_READ) begin
              state <= DFPC_READ;
            end else if (reg_wdata == DFPC_CMD_PROGRAM) begin
              state <= DFPC_PROGRAM;
            end else if (reg_wdata == DFPC_CMD_VERIFY) begin
              state <= DFPC_VERIFY;
            end else if (reg_wdata == DFPC_CMD_ERASE) begin
              state <= DFPC_ERASE;
            end else if (reg_wdata == DFPC_CMD_ERASE_ALL) begin
              state <= DFPC_ERASE_ALL;
            end
          end
        end
        DFPC_READ: begin
          state <= DFPC_IDLE;
        end
        DFPC_VERIFY: begin
          command_and_result <= (page_ok && verify_match) ? 8'h00 : DFPC_VERIFY_FAIL;
          state <= DFPC_IDLE;
        end
        DFPC_PROGRAM, DFPC_ERASE: begin
          // an out-of-range page never starts the timer, so end at once
          if (timer_done || !page_ok) begin
            state <= DFPC_IDLE;
          end
        end
        DFPC_ERASE_ALL: begin
          if (timer_done) begin
            state <= DFPC_IDLE;
          end
        end
        default: begin
          state <= DFPC_IDLE;
        end
      endcase
    end
  end

  // array update at the end of a timed operation; no reset, it is nonvolatile
  genvar gp, gb;
  generate
    for (gp = 0; gp < PAGES; gp++) begin : g_page
      for (gb = 0; gb < DFPC_PAGE_BYTES; gb++) begin : g_byte
        always_ff @(posedge core_clk) begin
          if (timer_done && state == DFPC_ERASE_ALL) begin
            flash_array[gp][gb] <= DFPC_ERASED;
          end else if (timer_done && page_ok && page_idx == 8'(gp)) begin
            if (state == DFPC_ERASE) begin
              flash_array[gp][gb] <= DFPC_ERASED;
            end else if (state == DFPC_PROGRAM &&
                flash_array[gp][gb] == DFPC_ERASED) begin
              flash_array[gp][gb] <= page_data_bytes[gb];
            end
          end
        end
      end
    end
  endgenerate

  // stall and interrupt hold rise in the cycle after the command write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      core_stall <= 1'b0;
      irq_hold <= 1'b0;
    end else begin
      if (reg_read) begin
        reg_rdata <= next_rdata;
      end
      core_stall <= cmd_write ? cmd_acts : run_stall;
      irq_hold <= cmd_write ? cmd_acts : run_stall;
    end
  end
endmodule

// ===== dfpc_core_props.sv
// checker for the page controller: stall timing, refusals and read data hold
// assumes it is bound into dfpc_core and sees only its ports
`timescale 1ns/1ps
module dfpc_core_props #(
  parameter int PAGES = 160
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic core_stall,
  input wire logic irq_hold
);
  import dfpc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [7:0] pg;
  // writes while stalled are dropped, so the tracked page follows only idle writes
  wire idle_wr = reg_write && !core_stall;
  wire cmd_wr = idle_wr && reg_addr == DFPC_ADDR_COMMAND;
  wire act = cmd_wr && (reg_wdata inside {8'h01, 8'h02, 8'h04, 8'h05, 8'h06});
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) pg <= 8'h00;
    else if (idle_wr && reg_addr == DFPC_ADDR_PAGE_SELECT) pg <= reg_wdata;
  end
  sequence s_one_cycle;
    core_stall ##1 !core_stall;
  endsequence
  AST_IRQ_HOLD: assert property (irq_hold == core_stall)
    else $error("irq hold differs from stall");
  AST_START: assert property (act |=> core_stall)
    else $error("command did not stall at once");
  AST_RESERVED: assert property (cmd_wr && !(reg_wdata inside {8'h01, 8'h02, 8'h04, 8'h05,
    8'h06}) |=> !core_stall)
    else $error("reserved code stalled");
  AST_READ: assert property (cmd_wr && reg_wdata == DFPC_CMD_READ |=> s_one_cycle)
    else $error("read stall not one cycle");
  AST_VERIFY: assert property (cmd_wr && reg_wdata == DFPC_CMD_VERIFY |=> s_one_cycle)
    else $error("verify stall not one cycle");
  AST_RANGE: assert property (act && reg_wdata != DFPC_CMD_ERASE_ALL && pg > PAGES - 1
    |=> s_one_cycle)
    else $error("page out of range not refused");
  AST_PROG: assert property (cmd_wr && reg_wdata == DFPC_CMD_PROGRAM && pg <= PAGES - 1
    |=> core_stall [*3])
    else $error("program too short");
  AST_ERASE_ALL: assert property (cmd_wr && reg_wdata == DFPC_CMD_ERASE_ALL
    |=> core_stall [*8])
    else $error("erase all too short");
  AST_RDATA: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("read data moved without read");
endmodule
bind dfpc_core dfpc_core_props #(.PAGES(PAGES)) u_props (.core_clk(core_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .core_stall(core_stall), .irq_hold(irq_hold));

// ===== test_dfpc_core.sv
// testbench for the page controller: register table, commands, refusals
// assumes a short timing word so erases take a few hundred cycles
`timescale 1ns/1ps
module test_dfpc_core;
  import dfpc_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic core_stall;
  logic irq_hold;
  logic [7:0] rd_val;
  int err_count = 0;
  int n_compared = 0;
  int n_cyc;
  // rows: address, reset value, written value, read back
  logic [31:0] rows [10] = '{32'hBC005A5A, 32'hBD00A5A5, 32'hBE003C3C, 32'hBF00C3C3,
    32'hC6009F9F, 32'hB9000000, 32'hBA520202, 32'hBB040000, 32'hC4C9C9C9, 32'h80007700};
  always #4 core_clk = ~core_clk;
  dfpc_core #(.PAGES(160)) DUT (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .core_stall(core_stall), .irq_hold(irq_hold));
  task end_of_test;
    $display("mismatches %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task chk_cyc(input string nm, input int lo, input int hi);
    n_compared++;
    if (n_cyc < lo || n_cyc > hi) begin
      err_count++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, n_cyc);
    end
  endtask
  // a cycle passes before each strobe so no strobe is set twice in one step
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk); #1;
    reg_addr = a; reg_wdata = d; reg_write = 1'b1;
    @(posedge core_clk); #1;
    reg_write = 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge core_clk); #1;
    reg_addr = a; reg_read = 1'b1;
    @(posedge core_clk); #1;
    reg_read = 1'b0;
    rd_val = reg_rdata;
  endtask
  task wait_idle;
    n_cyc = 0;
    while (core_stall !== 1'b0 && n_cyc < 5000) begin
      @(posedge core_clk); #1;
      n_cyc++;
    end
  endtask
  task cmd(input logic [7:0] c);
    wr(DFPC_ADDR_COMMAND, c);
    wait_idle();
  endtask
  task page_io(input logic [7:0] pg, input logic [7:0] c, input logic [31:0] d);
    wr(DFPC_ADDR_PAGE_SELECT, pg);
    for (int i = 0; i < 4; i++) wr(DFPC_ADDR_BYTE_ONE + i[7:0], d[31-8*i -: 8]);
    cmd(c);
  endtask
  // data registers are preloaded with the inverse so a lost read shows
  task chk_page(input logic [7:0] pg, input logic [31:0] exp);
    page_io(pg, DFPC_CMD_READ, ~exp);
    for (int i = 0; i < 4; i++) begin
      rd(DFPC_ADDR_BYTE_ONE + i[7:0]);
      chk8("page byte", exp[31-8*i -: 8], rd_val);
    end
  endtask
  initial begin
    #100000;
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    #1 rst = 1'b0;
    foreach (rows[i]) begin
      rd(rows[i][31:24]);
      chk8("reset value", rows[i][23:16], rd_val);
      if (rows[i][31:24] != DFPC_ADDR_COMMAND) wr(rows[i][31:24], rows[i][15:8]);
      rd(rows[i][31:24]);
      chk8("read back", rows[i][7:0], rd_val);
    end
    cmd(DFPC_CMD_ERASE_ALL);
    chk_cyc("erase all cycles", 400, 420);
    chk_page(8'h00, 32'hFFFFFFFF);
    chk_page(8'h9F, 32'hFFFFFFFF);
    page_io(8'h04, DFPC_CMD_PROGRAM, 32'h11223344);
    chk_cyc("program cycles", 6, 16);
    page_io(8'h03, DFPC_CMD_PROGRAM, 32'h11223344);
    chk_page(8'h03, 32'h11223344);
    page_io(8'h03, DFPC_CMD_VERIFY, 32'h11223344);
    rd(DFPC_ADDR_COMMAND);
    chk8("verify match", 8'h00, rd_val);
    page_io(8'h03, DFPC_CMD_VERIFY, 32'h11FF3344);
    rd(DFPC_ADDR_COMMAND);
    chk8("verify mismatch", 8'h01, rd_val);
    wr(DFPC_ADDR_PAGE_SELECT, 8'h03);
    cmd(DFPC_CMD_READ);
    wr(DFPC_ADDR_BYTE_TWO, 8'hF3);
    cmd(DFPC_CMD_ERASE);
    chk_cyc("erase cycles", 400, 420);
    cmd(DFPC_CMD_PROGRAM);
    chk_page(8'h03, 32'h11F33344);
    chk_page(8'h04, 32'h11223344);
    page_io(8'h03, DFPC_CMD_PROGRAM, 32'h00000000);
    chk_page(8'h03, 32'h11F33344);
    page_io(8'hA0, DFPC_CMD_PROGRAM, 32'h00000000);
    chk_cyc("refused cycles", 1, 1);
    chk_page(8'h00, 32'hFFFFFFFF);
    wr(DFPC_ADDR_PAGE_SELECT, 8'h02);
    wr(DFPC_ADDR_COMMAND, DFPC_CMD_ERASE_ALL);
    chk8("irq hold", 8'h01, {7'h00, irq_hold});
    wr(DFPC_ADDR_PAGE_SELECT, 8'h05);
    wait_idle();
    rd(DFPC_ADDR_PAGE_SELECT);
    chk8("busy write dropped", 8'h02, rd_val);
    cmd(8'h07);
    chk_cyc("reserved cycles", 0, 0);
    cmd(8'h03);
    chk_cyc("reserved 03 cycles", 0, 0);
    wr(DFPC_ADDR_PAGE_SELECT, 8'hA0);
    cmd(DFPC_CMD_ERASE_ALL);
    chk_cyc("erase all bad page cycles", 400, 420);
    // a second reset after the last command must restore the timing word low byte
    rst = 1'b1;
    @(posedge core_clk); #1;
    rst = 1'b0;
    rd(DFPC_ADDR_TIMING_LOW);
    chk8("timing low after reset", 8'h52, rd_val);
    end_of_test();
  end
endmodule
